// [rtl/csl_consts.svh]
// timing, width and encoding constants for the configuration start-up loader
`ifndef CSL_CONSTS_SVH
`define CSL_CONSTS_SVH
`define CSL_REF_PERIOD_NS  100
`define CSL_NS_PER_MS      1000000
`define CSL_NS_PER_US      1000
`define CSL_POR_SHORT_MS   10
`define CSL_POR_LONG_MS    40
`define CSL_MASTER_WAIT_US 250
`define CSL_FIRST_CLK_US   4
`define CSL_POR_SHORT_CYC  ((`CSL_POR_SHORT_MS*`CSL_NS_PER_MS+`CSL_REF_PERIOD_NS-1)/`CSL_REF_PERIOD_NS)
`define CSL_POR_LONG_CYC   ((`CSL_POR_LONG_MS*`CSL_NS_PER_MS+`CSL_REF_PERIOD_NS-1)/`CSL_REF_PERIOD_NS)
`define CSL_MASTER_WAIT_CYC ((`CSL_MASTER_WAIT_US*`CSL_NS_PER_US)/`CSL_REF_PERIOD_NS)
`define CSL_FIRST_CLK_CYC  ((`CSL_FIRST_CLK_US*`CSL_NS_PER_US+`CSL_REF_PERIOD_NS-1)/`CSL_REF_PERIOD_NS)
`define CSL_CLEAR_PASS_CYC 19'h00040
`define CSL_TMR_W          19
`define CSL_TMR_ONE        19'h00001
`define CSL_BYTE_BITS      4'h8
`define CSL_BITCNT_W       4
`define CSL_BUSY_MIN_TICKS 4'h2
`define CSL_GRAY_W         3
`define CSL_SYNC_W         17
`define CSL_STATUS_LOW     7'h7F
`define CSL_MODE_SLAVE_SER 3'h7
`define CSL_MODE_MSTR_SER  3'h0
`define CSL_MODE_SYNC_PER  3'h3
`define CSL_MODE_ASYNC_PER 3'h5
`define CSL_MODE_MSTR_HIGH 3'h6
`define CSL_MODE_MSTR_LOW  3'h4
`endif

// [rtl/csl_pkg.sv]
// types shared by the configuration start-up loader
`include "csl_consts.svh"
package csl_pkg;
   typedef enum logic [2:0] {
      CSL_SLAVE_SERIAL  = `CSL_MODE_SLAVE_SER,
      CSL_MASTER_SERIAL = `CSL_MODE_MSTR_SER,
      CSL_SYNC_PERIPH   = `CSL_MODE_SYNC_PER,
      CSL_ASYNC_PERIPH  = `CSL_MODE_ASYNC_PER,
      CSL_MASTER_HIGH   = `CSL_MODE_MSTR_HIGH,
      CSL_MASTER_LOW    = `CSL_MODE_MSTR_LOW
   } csl_mode_t;
   typedef enum logic [2:0] {
      ST_POWERON, ST_CLEAR, ST_WAIT, ST_MASTER_WAIT, ST_LOAD, ST_DONE
   } csl_state_t;
   typedef struct packed {
      logic mode_pin_two;
      logic mode_pin_one;
      logic mode_pin_zero;
   } csl_mode_pins_t;
   typedef struct packed {
      logic       chip_select_low_n;
      logic       chip_select_high;
      logic       write_strobe_n;
      logic       read_strobe_n;
      logic [7:0] data;
   } csl_periph_t;
endpackage

// [rtl/csl_loader.sv]
// configuration start-up control and asynchronous peripheral byte loader
// Functional notes
// - while clear input is low, keep clearing memory; never start configuration
// - after clear rises, run one more full clear pass, then check wait line
// - clear input low forces wait/error line low as long as it stays low
// - wait/error line held low after clearing keeps the device waiting
// - on wait/error line release, capture mode pins and get ready to load
// - master modes wait up to 250 us more after the wait line rises
// - written byte is latched at the rising edge of the write strobe
// - busy stays asserted between 2 and 9 config clock periods per byte
// - busy shortest into empty converter, longest when shifter still full
// - mode pins 111,000,011,101,110,100 select the six load modes
// - master power-on delay 10-40 ms with mode0 high, 40-130 ms low
// - loading indicators high and low until configuration completes
// - during loading a data error pulls the wait/error line low
// - peripheral and parallel modes take bytes on eight data pins; here only the asynchronous peripheral mode takes them
// - config clock driven in master and async modes, input otherwise
// - byte taken at trailing edge of selects-and-strobe, into converter
// - busy on receipt, ready once buffer passed byte to shifter
`timescale 1ns/1ps
`include "csl_consts.svh"
module csl_loader #(
   parameter logic [`CSL_TMR_W-1:0] POR_SHORT_CYC = `CSL_TMR_W'(`CSL_POR_SHORT_CYC),
   parameter logic [`CSL_TMR_W-1:0] POR_LONG_CYC  = `CSL_TMR_W'(`CSL_POR_LONG_CYC)
) (
   input  wire logic                    REF_CLK,
   input  wire logic                    RESET_N,
   input  wire logic                    CE,
   input  wire logic                    CONFIG_CLOCK_IN,
   output logic                         CONFIG_CLOCK_OUT,
   output logic                         CONFIG_CLOCK_OE,
   input  wire logic                    CLEAR_N,
   input  wire logic                    WAIT_ERR_IN,
   output logic                         WAIT_ERR_OUT,
   output logic                         WAIT_ERR_OE,
   input  wire csl_pkg::csl_mode_pins_t MODE_PINS,
   input  wire csl_pkg::csl_periph_t    PERIPH,
   output logic                         READY_NOT_BUSY,
   output logic [7:0]                   DATA_OUT,
   output logic                         DATA_OE,
   output logic                         HIGH_WHILE_LOADING,
   output logic                         LOW_WHILE_LOADING,
   output logic                         PINS_RELEASED,
   output logic                         CONFIG_ACTIVE,
   output csl_pkg::csl_mode_t           LOAD_MODE,
   output logic                         SERIAL_BIT,
   output logic                         SERIAL_VALID,
   input  wire logic                    DATA_ERROR,
   input  wire logic                    LOAD_COMPLETE
);
   import csl_pkg::*;

   localparam logic [`CSL_TMR_W-1:0] MASTER_WAIT = `CSL_TMR_W'(`CSL_MASTER_WAIT_CYC);
   localparam logic [`CSL_TMR_W-1:0] FIRST_CLK   = `CSL_TMR_W'(`CSL_FIRST_CLK_CYC);

   function automatic csl_mode_t decode_mode(input csl_mode_pins_t p);
      csl_mode_t m;
      m = CSL_SLAVE_SERIAL;
      unique case ({p.mode_pin_two, p.mode_pin_one, p.mode_pin_zero})
         `CSL_MODE_MSTR_SER:  m = CSL_MASTER_SERIAL;
         `CSL_MODE_SYNC_PER:  m = CSL_SYNC_PERIPH;
         `CSL_MODE_ASYNC_PER: m = CSL_ASYNC_PERIPH;
         `CSL_MODE_MSTR_HIGH: m = CSL_MASTER_HIGH;
         `CSL_MODE_MSTR_LOW:  m = CSL_MASTER_LOW;
         // two unused codes fall back to slave serial, the passive choice
         default:             m = CSL_SLAVE_SERIAL;
      endcase
      return m;
   endfunction

   function automatic logic is_master(input csl_mode_t m);
      return m inside {CSL_MASTER_SERIAL, CSL_MASTER_HIGH, CSL_MASTER_LOW};
   endfunction

   function automatic logic is_internal(input csl_mode_t m);
      return is_master(m) || (m == CSL_ASYNC_PERIPH);
   endfunction

   // pin inputs: three stages, a change counts once stages two and three agree
   logic [`CSL_SYNC_W-1:0] pin_raw;
   logic [`CSL_SYNC_W-1:0] pin_s1;
   logic [`CSL_SYNC_W-1:0] pin_s2;
   logic [`CSL_SYNC_W-1:0] pin_s3;
   logic [`CSL_SYNC_W-1:0] pin_filt;
   logic                   clear_n_f;
   logic                   wait_f;
   csl_mode_pins_t         mode_f;
   csl_periph_t            per_f;

   assign pin_raw = {CLEAR_N, WAIT_ERR_IN, MODE_PINS, PERIPH};
   assign {clear_n_f, wait_f, mode_f, per_f} = pin_filt;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_s1   <= '1;
         pin_s2   <= '1;
         pin_s3   <= '1;
         pin_filt <= '1;
      end else if (CE) begin
         pin_s1   <= pin_raw;
         pin_s2   <= pin_s1;
         pin_s3   <= pin_s2;
         pin_filt <= (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_filt);
      end
   end

   // start-up sequencer
   csl_state_t             state;
   csl_mode_t              mode;
   logic [`CSL_TMR_W-1:0]  tmr;
   logic [`CSL_TMR_W-1:0]  por_target;
   logic                   pass_again;
   logic                   err;
   logic                   early_clock;
   logic                   pass_end;

   // mode pins are read live during power-on to pick the delay length
   assign por_target = (is_master(decode_mode(mode_f)) && !mode_f.mode_pin_zero)
                       ? POR_LONG_CYC : POR_SHORT_CYC;
   assign pass_end   = (tmr == `CSL_CLEAR_PASS_CYC - `CSL_TMR_ONE);

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state      <= ST_POWERON;
         tmr        <= '0;
         pass_again <= 1'b0;
      end else if (CE) begin
         if (!clear_n_f && state != ST_POWERON && state != ST_CLEAR) begin
            state      <= ST_CLEAR;
            tmr        <= '0;
            pass_again <= 1'b1;
         end else begin
            unique case (state)
               ST_POWERON: begin
                  if (tmr >= por_target) begin
                     state <= ST_CLEAR;
                     tmr   <= '0;
                  end else begin
                     tmr <= tmr + `CSL_TMR_ONE;
                  end
               end
               ST_CLEAR: begin
                  if (pass_end) begin
                     tmr <= '0;
                     if (!clear_n_f || pass_again) begin
                        pass_again <= !clear_n_f;
                     end else begin
                        state <= ST_WAIT;
                     end
                  end else begin
                     tmr <= tmr + `CSL_TMR_ONE;
                     if (!clear_n_f) begin
                        pass_again <= 1'b1;
                     end
                  end
               end
               ST_WAIT: begin
                  // stays here while the line is held low from outside
                  if (wait_f) begin
                     tmr   <= '0;
                     state <= is_master(decode_mode(mode_f)) ? ST_MASTER_WAIT : ST_LOAD;
                  end
               end
               ST_MASTER_WAIT: begin
                  if (tmr >= MASTER_WAIT - `CSL_TMR_ONE) begin
                     tmr   <= '0;
                     state <= ST_LOAD;
                  end else begin
                     tmr <= tmr + `CSL_TMR_ONE;
                  end
               end
               ST_LOAD: begin
                  if (tmr < FIRST_CLK) begin
                     tmr <= tmr + `CSL_TMR_ONE;
                  end
                  if (LOAD_COMPLETE) begin
                     state <= ST_DONE;
                  end
               end
               ST_DONE: begin
                  state <= ST_DONE;
               end
            endcase
         end
      end
   end

   // mode is captured once, on leaving the wait state
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         mode <= CSL_SLAVE_SERIAL;
      end else if (CE) begin
         if (state == ST_WAIT && wait_f && clear_n_f) begin
            mode <= decode_mode(mode_f);
         end
      end
   end

   // data error flag, cleared only by a new clear sequence
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         err <= 1'b0;
      end else if (CE) begin
         if (state == ST_LOAD && (DATA_ERROR || early_clock)) begin
            err <= 1'b1;
         end else if (state == ST_CLEAR) begin
            err <= 1'b0;
         end
      end
   end

   assign WAIT_ERR_OUT = 1'b0;

   // status pins; wait line is open drain, so only its enable moves
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         WAIT_ERR_OE        <= 1'b1;
         HIGH_WHILE_LOADING <= 1'b1;
         LOW_WHILE_LOADING  <= 1'b0;
         PINS_RELEASED      <= 1'b0;
         CONFIG_ACTIVE      <= 1'b0;
      end else if (CE) begin
         WAIT_ERR_OE        <= state == ST_POWERON || state == ST_CLEAR
                               || !clear_n_f || err;
         HIGH_WHILE_LOADING <= state != ST_DONE;
         LOW_WHILE_LOADING  <= state == ST_DONE;
         PINS_RELEASED      <= state == ST_DONE;
         CONFIG_ACTIVE      <= state == ST_LOAD;
      end
   end

   assign LOAD_MODE = mode;

   // internal configuration clock: ref clock divided by two while loading
   logic clk_run;
   logic tick;

   assign clk_run = state == ST_LOAD && is_internal(mode);
   assign tick    = clk_run && !CONFIG_CLOCK_OUT;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CONFIG_CLOCK_OUT <= 1'b0;
         CONFIG_CLOCK_OE  <= 1'b0;
      end else if (CE) begin
         CONFIG_CLOCK_OUT <= clk_run && !CONFIG_CLOCK_OUT;
         CONFIG_CLOCK_OE  <= clk_run;
      end
   end

   // asynchronous peripheral write and status read
   logic       async_on;
   logic       wr_cond;
   logic       rd_cond;
   logic       wr_prev;
   logic [7:0] wr_data;
   logic       accept;
   logic       busy;

   assign async_on = state == ST_LOAD && mode == CSL_ASYNC_PERIPH;
   assign wr_cond  = !per_f.chip_select_low_n && per_f.chip_select_high
                     && !per_f.write_strobe_n && per_f.read_strobe_n;
   assign rd_cond  = !per_f.chip_select_low_n && per_f.chip_select_high
                     && !per_f.read_strobe_n && per_f.write_strobe_n;
   // a write landing while busy is dropped; the converter cannot hold it
   assign accept   = async_on && wr_prev && !wr_cond && !busy;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_prev <= 1'b0;
         wr_data <= '0;
      end else if (CE) begin
         wr_prev <= wr_cond;
         if (wr_cond) begin
            wr_data <= per_f.data;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         DATA_OE  <= 1'b0;
         DATA_OUT <= '0;
      end else if (CE) begin
         DATA_OE  <= async_on && rd_cond;
         DATA_OUT <= {!busy, `CSL_STATUS_LOW};
      end
   end

   assign READY_NOT_BUSY = !busy;

   // double-buffered parallel-to-serial converter
   logic [7:0]               hold;
   logic                     hold_full;
   logic [7:0]               shreg;
   logic [`CSL_BITCNT_W-1:0] bitcnt;
   logic [`CSL_BITCNT_W-1:0] busy_ticks;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         hold         <= '0;
         hold_full    <= 1'b0;
         shreg        <= '0;
         bitcnt       <= '0;
         busy         <= 1'b0;
         busy_ticks   <= '0;
         SERIAL_BIT   <= 1'b0;
         SERIAL_VALID <= 1'b0;
      end else if (CE) begin
         SERIAL_VALID <= 1'b0;
         if (!async_on) begin
            hold_full <= 1'b0;
            bitcnt    <= '0;
            busy      <= 1'b0;
         end else begin
            if (accept) begin
               hold       <= wr_data;
               hold_full  <= 1'b1;
               busy       <= 1'b1;
               busy_ticks <= '0;
            end
            if (tick) begin
               if (bitcnt != '0) begin
                  SERIAL_BIT   <= shreg[0];
                  SERIAL_VALID <= 1'b1;
                  shreg        <= shreg >> 1;
                  bitcnt       <= bitcnt - `CSL_BITCNT_W'(1);
               end else if (hold_full) begin
                  shreg     <= hold;
                  bitcnt    <= `CSL_BYTE_BITS;
                  hold_full <= 1'b0;
               end
               if (busy) begin
                  busy_ticks <= busy_ticks + `CSL_BITCNT_W'(1);
                  // release no sooner than the second tick, and only once
                  // the buffer has handed its byte to the shifter
                  if (busy_ticks >= `CSL_BUSY_MIN_TICKS - `CSL_BITCNT_W'(1)
                      && (!hold_full || bitcnt == '0)) begin
                     busy <= 1'b0;
                  end
               end
            end
         end
      end
   end

   // link side: external config clock edges, counted in gray code
   logic                   ext_run;
   logic                   run_l1;
   logic                   run_l2;
   logic [`CSL_GRAY_W-1:0] lnk_bin;
   logic [`CSL_GRAY_W-1:0] lnk_gray;
   logic [`CSL_GRAY_W-1:0] next_bin;

   assign next_bin = lnk_bin + `CSL_GRAY_W'(1);

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ext_run <= 1'b0;
      end else if (CE) begin
         ext_run <= state == ST_LOAD && !is_internal(mode);
      end
   end

   always_ff @(posedge CONFIG_CLOCK_IN or negedge RESET_N) begin
      if (!RESET_N) begin
         run_l1   <= 1'b0;
         run_l2   <= 1'b0;
         lnk_bin  <= '0;
         lnk_gray <= '0;
      end else begin
         run_l1 <= ext_run;
         run_l2 <= run_l1;
         if (run_l2) begin
            lnk_bin  <= next_bin;
            lnk_gray <= next_bin ^ (next_bin >> 1);
         end
      end
   end

   logic [`CSL_GRAY_W-1:0] gry_s1;
   logic [`CSL_GRAY_W-1:0] gry_s2;
   logic [`CSL_GRAY_W-1:0] gry_s3;
   logic [`CSL_GRAY_W-1:0] gry_seen;
   logic                   ext_edge;

   assign ext_edge = gry_s2 == gry_s3 && gry_s3 != gry_seen;
   // an edge before the start-up gap has passed is treated as a data error
   assign early_clock = ext_edge && tmr < FIRST_CLK;

   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         gry_s1   <= '0;
         gry_s2   <= '0;
         gry_s3   <= '0;
         gry_seen <= '0;
      end else if (CE) begin
         gry_s1 <= lnk_gray;
         gry_s2 <= gry_s1;
         gry_s3 <= gry_s2;
         if (ext_edge) begin
            gry_seen <= gry_s3;
         end
      end
   end

   // checks assume CE held high
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);

   clear_forces_wait_a: assert property (
      !clear_n_f |=> WAIT_ERR_OE) else $error("clear low but wait line released");
   clear_blocks_load_a: assert property (
      !clear_n_f |=> state inside {ST_POWERON, ST_CLEAR})
      else $error("left clearing while clear low");
   last_pass_a: assert property (
      $rose(state == ST_WAIT) |-> $past(clear_n_f) && !$past(pass_again))
      else $error("wait entered without a clean final pass");
   wait_holds_a: assert property (
      state == ST_WAIT && !wait_f && clear_n_f |=> state == ST_WAIT)
      else $error("started while wait line held low");
   mode_capture_a: assert property (
      state == ST_WAIT && wait_f && clear_n_f |=> mode == decode_mode($past(mode_f)))
      else $error("mode not captured on release");
   master_wait_a: assert property (
      $rose(state == ST_LOAD) && is_master(mode) |-> $past(state) == ST_MASTER_WAIT
      && $past(tmr) == MASTER_WAIT - `CSL_TMR_ONE) else $error("master wait skipped");
   busy_short_a: assert property (
      $fell(READY_NOT_BUSY) |-> !READY_NOT_BUSY [*3]) else $error("busy too short");
   busy_long_a: assert property (
      $fell(READY_NOT_BUSY) |-> ##[3:18] READY_NOT_BUSY) else $error("busy too long");
   accept_latch_a: assert property (
      accept |=> hold_full && busy && hold == $past(wr_data))
      else $error("byte not latched at strobe end");
   mode_hold_a: assert property (
      state == ST_LOAD && $past(state) == ST_LOAD |-> $stable(mode))
      else $error("mode changed while loading");
   loading_pins_a: assert property (
      state != ST_DONE && $past(state) != ST_DONE |-> HIGH_WHILE_LOADING
      && !LOW_WHILE_LOADING) else $error("loading indicators wrong");
   error_wait_a: assert property (
      state == ST_LOAD && DATA_ERROR |=> ##1 WAIT_ERR_OE)
      else $error("data error not flagged");
   clock_source_a: assert property (
      state == ST_LOAD && $past(state) == ST_LOAD |-> CONFIG_CLOCK_OE == is_internal(mode))
      else $error("config clock direction wrong");
   poweron_wait_a: assert property (
      state == ST_POWERON && $past(state) == ST_POWERON |-> WAIT_ERR_OE)
      else $error("wait line released during power-on");

   async_load_c: cover property (state == ST_LOAD && mode == CSL_ASYNC_PERIPH);
   byte_taken_c: cover property (accept);
   busy_full_c:  cover property (busy && hold_full && bitcnt != '0);
   master_run_c: cover property ($rose(state == ST_LOAD) && is_master(mode));
endmodule

// [bench/csl_host_model.sv]
// microprocessor side of the asynchronous peripheral load port
`timescale 1ns/1ps
module csl_host_model (
   input  wire logic           ref_clk,
   input  wire logic           ready_not_busy,
   input  wire logic           data_oe,
   input  wire logic [7:0]     data_in,
   output csl_pkg::csl_periph_t periph
);
   import csl_pkg::*;
   initial periph = '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00};

   // one write; data is held past the strobe edge, then turned over so a late sample shows
   task automatic wr(input logic [7:0] b);
      int k;
      k = 0;
      while (ready_not_busy !== 1'b1 && k < 50) begin
         @(negedge ref_clk);
         k++;
      end
      @(negedge ref_clk);
      periph <= '{1'b0, 1'b1, 1'b0, 1'b1, b};
      repeat (4) @(negedge ref_clk);
      periph.write_strobe_n <= 1'b1;
      @(negedge ref_clk);
      periph <= '{1'b1, 1'b0, 1'b1, 1'b1, ~b};
   endtask

   // status read: selects and read strobe stand until the status byte is taken
   task automatic rd(output logic [8:0] r);
      @(negedge ref_clk);
      periph <= '{1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
      repeat (6) @(negedge ref_clk);
      r = {data_oe, data_in};
      periph <= '{1'b1, 1'b0, 1'b1, 1'b1, 8'h00};
   endtask
endmodule

// [bench/csl_loader_tb.sv]
// self-checking bench for the configuration start-up loader
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module csl_loader_tb;
   import csl_pkg::*;
   logic           ref_clk = 1'b0;
   logic           link_clk = 1'b0;
   logic           reset_n = 1'b0;
   logic           clear_n = 1'b1;
   logic           hold_wait = 1'b1;
   logic           data_error = 1'b0;
   logic           load_complete = 1'b0;
   csl_mode_pins_t mode_pins = 3'h5;
   csl_periph_t    periph;
   csl_mode_t      load_mode;
   logic           ready, wait_oe, wait_out, clk_oe, config_clock, hwl, lwl, active, released;
   logic           sbit, svalid, dat_oe;
   logic [7:0]     dat;
   logic [8:0]     stat;
   logic           sbits[$];
   logic [2:0]     modes [6] = '{3'h7, 3'h0, 3'h3, 3'h5, 3'h6, 3'h4};
   int             num_errors = 0;
   int             tests_run = 0;
   int             n, b1;
   // pull-up on the shared wait/error wire
   wire            wait_wire = (wait_oe ? wait_out : 1'b1) & !hold_wait;

   always #50 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (svalid === 1'b1) sbits.push_back(sbit);

   csl_host_model i_host (.ref_clk(ref_clk), .ready_not_busy(ready), .data_oe(dat_oe),
      .data_in(dat), .periph(periph));
   csl_loader #(.POR_SHORT_CYC(19'h00014), .POR_LONG_CYC(19'h00028)) i_dut (
      .REF_CLK(ref_clk), .RESET_N(reset_n), .CE(1'b1), .CONFIG_CLOCK_IN(link_clk),
      .CONFIG_CLOCK_OUT(config_clock), .CONFIG_CLOCK_OE(clk_oe), .CLEAR_N(clear_n),
      .WAIT_ERR_IN(wait_wire), .WAIT_ERR_OUT(wait_out), .WAIT_ERR_OE(wait_oe),
      .MODE_PINS(mode_pins), .PERIPH(periph), .READY_NOT_BUSY(ready), .DATA_OUT(dat),
      .DATA_OE(dat_oe), .HIGH_WHILE_LOADING(hwl), .LOW_WHILE_LOADING(lwl),
      .PINS_RELEASED(released),
      .CONFIG_ACTIVE(active), .LOAD_MODE(load_mode), .SERIAL_BIT(sbit),
      .SERIAL_VALID(svalid), .DATA_ERROR(data_error), .LOAD_COMPLETE(load_complete));

   task automatic cyc(input int k);
      repeat (k) @(negedge ref_clk);
   endtask

   task automatic wait_for(ref logic s, input logic v, input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic wr_busy(input logic [7:0] b);
      i_host.wr(b);
      wait_for(ready, 1'b0, 10);
      wait_for(ready, 1'b1, 40);
      `CHK(n >= 3 && n <= 18, 1'b1)
   endtask

   task automatic restart(input logic [2:0] m);
      clear_n = 1'b0;
      hold_wait = 1'b1;
      mode_pins = m;
      cyc(8);
      `CHK({wait_oe, active}, 2'b10)
      clear_n = 1'b1;
      cyc(200);
      `CHK({wait_oe, active}, 2'b00)
      hold_wait = 1'b0;
      wait_for(active, 1'b1, 3000);
      `CHK(m[0] ? n < 20 : (n > 2400 && n < 2520), 1'b1)
      mode_pins = ~m;
      cyc(4);
      `CHK(load_mode, m)
      `CHK(clk_oe, !m[0] || m == 3'h5)
      b1 = config_clock;
      cyc(1);
      `CHK(config_clock, (!m[0] || m == 3'h5) ? !b1[0] : 1'b0)
      `CHK({hwl, lwl}, 2'b10)
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      cyc(2);
      `CHK({wait_oe, hwl, lwl}, 3'b110)
      cyc(14);
      reset_n = 1'b1;
      foreach (modes[i]) begin
         restart(modes[i]);
         if (modes[i] == 3'h5) begin
            sbits.delete();
            wr_busy(8'hA5);
            b1 = n;
            wr_busy(8'h3C);
            `CHK(n > b1, 1'b1)
            n = 0;
            while (sbits.size() < 12 && n < 300) begin
               cyc(1);
               n++;
            end
            for (int k = 0; k < 12; k++) `CHK(sbits[k], 16'h3CA5 >> k & 1'b1)
            i_host.rd(stat);
            `CHK(stat, 9'h1FF)
         end
         if (modes[i] == 3'h7) begin
            // a short link clock burst, well inside the required quiet gap
            #7;
            repeat (8) #3 link_clk = ~link_clk;
            cyc(8);
            `CHK(wait_oe, 1'b1)
         end
      end
      data_error = 1'b1;
      cyc(1);
      data_error = 1'b0;
      cyc(3);
      `CHK(wait_oe, 1'b1)
      load_complete = 1'b1;
      cyc(4);
      `CHK({hwl, lwl, active, released}, 4'b0101)
      end_sim();
   end

   initial begin
      #3000000;
      num_errors++;
      end_sim();
   end
endmodule
